// [core/inductive_sense_config_regs.sv]
// sensing configuration register bank behind the serial port
// Summary of operation
// RQ1 - min_resistance_range sets range floor; codes 0x20..0x3F are the valid fixed values
// RQ2 - host sets frequency code about 20% below unloaded sensor resonance
// RQ3 - frequency code is 68.94*log10(f/2000), rounded; device stores it unchanged
// RQ4 - config bits 4:3 pick amplitude 1, 2 or 4 V; 11 is reserved
// RQ5 - config bits 2:0 codes 010..111 pick 192..6144; 000, 001 reserved
// RQ6 - with active_power_select set, writes to offsets 0x01..0x05 are dropped
// RQ7 - config bits 7:5 are ignored on write and read back as zero
module inductive_sense_config_regs
   import sense_cfg_pkg::*;
(
   input  logic            clock,
   input  logic            reset_n,
   input  logic            csN,
   input  logic            sclk,
   input  logic            mosi,
   input  logic            activePowerSelect,
   output logic            miso,
   output logic            misoOe_n,
   output logic [7:0]      minResistanceRange,
   output logic            minResInRange,
   output logic [7:0]      minResonanceFrequency,
   output logic [1:0]      amplitudeSel,
   output logic            amplitudeReserved,
   output logic [12:0]     responseCycles,
   output logic            responseReserved
);

   logic [6:0]      addr;
   wr_req_s         wrReq;
   logic [7:0]      rdData;
   logic            wrAllowed;

   logic [7:0]      minRes_q, minRes_d;
   logic [7:0]      minFreq_q, minFreq_d;
   logic [4:0]      oscCfg_q, oscCfg_d;
   logic            resInRange_q, resInRange_d;
   logic [1:0]      ampSel_q, ampSel_d;
   logic            ampRsv_q, ampRsv_d;
   logic [12:0]     respCyc_q, respCyc_d;
   logic            respRsv_q, respRsv_d;

   serial_frame_slave u_port (
      .clock    (clock),
      .reset_n  (reset_n),
      .csN      (csN),
      .sclk     (sclk),
      .mosi     (mosi),
      .rdData   (rdData),
      .addr     (addr),
      .wrReq    (wrReq),
      .miso     (miso),
      .misoOe_n (misoOe_n)
   );

   // lock covers the whole 0x01..0x05 span, writes to offsets outside it are not gated by the level
   assign wrAllowed = wrReq.valid &&
                      !(activePowerSelect && wrReq.addr >= LOCK_FIRST_OFFSET &&
                        wrReq.addr <= LOCK_LAST_OFFSET); // RQ6

   always_comb begin
      if (addr == MIN_RES_OFFSET) begin
         rdData = minRes_q;
      end else if (addr == MIN_FREQ_OFFSET) begin
         rdData = minFreq_q;
      end else if (addr == OSC_CFG_OFFSET) begin
         rdData = {3'h0, oscCfg_q}; // RQ7
      end else begin
         rdData = 8'h00;
      end
   end

   always_comb begin
      minRes_d  = minRes_q;
      minFreq_d = minFreq_q;
      oscCfg_d  = oscCfg_q;
      if (wrAllowed) begin
         if (wrReq.addr == MIN_RES_OFFSET) begin
            minRes_d = wrReq.data; // RQ1
         end else if (wrReq.addr == MIN_FREQ_OFFSET) begin
            minFreq_d = wrReq.data; // RQ3
         end else if (wrReq.addr == OSC_CFG_OFFSET) begin
            oscCfg_d = wrReq.data[OSC_CFG_BITS-1:0]; // RQ7
         end
      end
   end

   // decoded settings follow the new register value in the same edge
   always_comb begin
      resInRange_d = (minRes_d >= RES_CODE_LO) && (minRes_d <= RES_CODE_HI); // RQ1
      ampSel_d     = oscCfg_d[AMP_MSB:AMP_LSB]; // RQ4
      ampRsv_d     = (oscCfg_d[AMP_MSB:AMP_LSB] == AMP_RESERVED); // RQ4
      respRsv_d    = (oscCfg_d[RESP_MSB:RESP_LSB] < RESP_FIRST_CODE); // RQ5
      // reserved response codes give zero rather than a guessed time
      if (respRsv_d) begin
         respCyc_d = 13'h0000;
      end else begin
         respCyc_d = RESP_BASE_CYCLES <<
                     (oscCfg_d[RESP_MSB:RESP_LSB] - RESP_FIRST_CODE); // RQ5
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         minRes_q     <= MIN_RES_RESET;
         minFreq_q    <= MIN_FREQ_RESET;
         oscCfg_q     <= OSC_CFG_RESET;
         resInRange_q <= 1'b0;
         ampSel_q     <= OSC_CFG_RESET[AMP_MSB:AMP_LSB];
         ampRsv_q     <= 1'b1;
         respCyc_q    <= RESP_BASE_CYCLES << 1;
         respRsv_q    <= 1'b0;
      end else begin
         minRes_q     <= minRes_d;
         minFreq_q    <= minFreq_d;
         oscCfg_q     <= oscCfg_d;
         resInRange_q <= resInRange_d;
         ampSel_q     <= ampSel_d;
         ampRsv_q     <= ampRsv_d;
         respCyc_q    <= respCyc_d;
         respRsv_q    <= respRsv_d;
      end
   end

   assign minResistanceRange    = minRes_q;
   assign minResInRange         = resInRange_q;
   assign minResonanceFrequency = minFreq_q;
   assign amplitudeSel          = ampSel_q;
   assign amplitudeReserved     = ampRsv_q;
   assign responseCycles        = respCyc_q;
   assign responseReserved      = respRsv_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence lockedWrite;
      wrReq.valid && activePowerSelect && wrReq.addr >= MIN_RES_OFFSET &&
      wrReq.addr <= OSC_CFG_OFFSET;
   endsequence

   sequence openWrite(logic [6:0] off);
      wrReq.valid && !activePowerSelect && wrReq.addr == off;
   endsequence

   a_lock_holds_regs: assert property ( // RQ6
      lockedWrite |=> $stable(minRes_q) && $stable(minFreq_q) && $stable(oscCfg_q))
      else $error("locked write changed a register");

   a_res_write_lands: assert property ( // RQ1
      openWrite(MIN_RES_OFFSET) |=> minRes_q == $past(wrReq.data))
      else $error("min resistance write lost");

   a_res_range_flag: assert property ( // RQ1
      minResInRange == (minRes_q >= 8'h20 && minRes_q <= 8'h3f))
      else $error("range flag disagrees with code");

   a_freq_write_lands: assert property ( // RQ3
      openWrite(MIN_FREQ_OFFSET) |=> minFreq_q == $past(wrReq.data))
      else $error("frequency code not stored unchanged");

   a_amp_follows_cfg: assert property ( // RQ4
      openWrite(OSC_CFG_OFFSET) |=> amplitudeSel == $past(wrReq.data[4:3]) &&
      amplitudeReserved == ($past(wrReq.data[4:3]) == 2'h3))
      else $error("amplitude select wrong after write");

   a_resp_top_code: assert property ( // RQ5
      openWrite(OSC_CFG_OFFSET) ##0 (wrReq.data[2:0] == 3'h7) |=> responseCycles == 13'h1800)
      else $error("code 111 did not give 6144");

   a_resp_low_code: assert property ( // RQ5
      openWrite(OSC_CFG_OFFSET) ##0 (wrReq.data[2:0] == 3'h2) |=> responseCycles == 13'h00c0)
      else $error("code 010 did not give 192");

   a_cfg_upper_zero: assert property ( // RQ7
      addr == OSC_CFG_OFFSET |-> rdData[7:5] == 3'h0)
      else $error("config upper bits not zero");

   // registers move only on an accepted write frame
   sequence idleCycle;
      !wrReq.valid;
   endsequence

   sequence respCodeWrite(logic [2:0] code);
      openWrite(OSC_CFG_OFFSET) ##0 (wrReq.data[2:0] == code);
   endsequence

   a_lock_holds_decode: assert property ( // RQ6
      lockedWrite |=> $stable(minResInRange) && $stable(amplitudeSel) &&
      $stable(responseCycles) && $stable(responseReserved))
      else $error("locked write changed a decoded setting");

   a_idle_holds_regs: assert property ( // RQ3
      idleCycle |=> $stable(minRes_q) && $stable(minFreq_q) && $stable(oscCfg_q))
      else $error("register changed without a write");

   a_cfg_upper_dropped: assert property ( // RQ7
      openWrite(OSC_CFG_OFFSET) |=> oscCfg_q == $past(wrReq.data[4:0]))
      else $error("config write not stored as its low five bits");

   a_res_flag_inside: assert property ( // RQ1
      openWrite(MIN_RES_OFFSET) ##0 (wrReq.data >= 8'h20 && wrReq.data <= 8'h3f)
      |=> minResInRange)
      else $error("valid resistance code not flagged");

   a_res_flag_outside: assert property ( // RQ1
      openWrite(MIN_RES_OFFSET) ##0 (wrReq.data < 8'h20 || wrReq.data > 8'h3f)
      |=> !minResInRange)
      else $error("invalid resistance code flagged as valid");

   // reserved codes must never present a usable response time
   a_resp_rsv_zero: assert property ( // RQ5
      openWrite(OSC_CFG_OFFSET) ##0 (wrReq.data[2:0] < 3'h2)
      |=> responseReserved && responseCycles == 13'h0000)
      else $error("reserved response code not flagged");

   a_resp_valid_flag: assert property ( // RQ5
      openWrite(OSC_CFG_OFFSET) ##0 (wrReq.data[2:0] >= 3'h2) |=> !responseReserved)
      else $error("valid response code flagged reserved");

   a_resp_code_three: assert property ( // RQ5
      respCodeWrite(3'h3) |=> responseCycles == 13'h0180)
      else $error("code 011 did not give 384");

   a_resp_code_four: assert property ( // RQ5
      respCodeWrite(3'h4) |=> responseCycles == 13'h0300)
      else $error("code 100 did not give 768");

   a_resp_code_five: assert property ( // RQ5
      respCodeWrite(3'h5) |=> responseCycles == 13'h0600)
      else $error("code 101 did not give 1536");

   a_resp_code_six: assert property ( // RQ5
      respCodeWrite(3'h6) |=> responseCycles == 13'h0c00)
      else $error("code 110 did not give 3072");

endmodule // inductive_sense_config_regs

// [core/sense_cfg_pkg.sv]
// shared constants and types for the sensing configuration register bank
package sense_cfg_pkg;

   localparam int           FRAME_BITS        = 16;
   localparam int           ADDR_BITS         = 7;
   localparam logic [4:0]   CMD_LAST_BIT      = 5'h07;
   localparam logic [4:0]   DATA_FIRST_BIT    = 5'h08;
   localparam logic [4:0]   DATA_LAST_BIT     = 5'h0f;
   localparam logic [4:0]   FRAME_END_COUNT   = 5'h10;

   // register offsets
   localparam logic [6:0]   LOCK_FIRST_OFFSET = 7'h01;
   localparam logic [6:0]   LOCK_LAST_OFFSET  = 7'h05;
   localparam logic [6:0]   MIN_RES_OFFSET    = 7'h02;
   localparam logic [6:0]   MIN_FREQ_OFFSET   = 7'h03;
   localparam logic [6:0]   OSC_CFG_OFFSET    = 7'h04;

   // reset values
   localparam logic [7:0]   MIN_RES_RESET     = 8'h14;
   localparam logic [7:0]   MIN_FREQ_RESET    = 8'h45;
   localparam logic [4:0]   OSC_CFG_RESET     = 5'h1b;

   // sense_oscillation_config fields
   localparam int           AMP_MSB           = 4;
   localparam int           AMP_LSB           = 3;
   localparam int           RESP_MSB          = 2;
   localparam int           RESP_LSB          = 0;
   localparam int           OSC_CFG_BITS      = 5;
   localparam logic [1:0]   AMP_RESERVED      = 2'h3;
   localparam logic [2:0]   RESP_FIRST_CODE   = 3'h2;
   localparam logic [12:0]  RESP_BASE_CYCLES  = 13'h00c0;

   // min_resistance_range valid code span
   localparam logic [7:0]   RES_CODE_LO       = 8'h20;
   localparam logic [7:0]   RES_CODE_HI       = 8'h3f;

   typedef struct packed {
      logic                 valid;
      logic [6:0]           addr;
      logic [7:0]           data;
   } wr_req_s;

endpackage

// [core/serial_frame_slave.sv]
// serial frame slave: command byte then data byte, mode 0
module serial_frame_slave
   import sense_cfg_pkg::*;
(
   input  logic            clock,
   input  logic            reset_n,
   input  logic            csN,
   input  logic            sclk,
   input  logic            mosi,
   input  logic [7:0]      rdData,
   output logic [6:0]      addr,
   output wr_req_s         wrReq,
   output logic            miso,
   output logic            misoOe_n
);

   logic            sclkPrev_q, sclkPrev_d;
   logic [4:0]      bitCnt_q, bitCnt_d;
   logic [6:0]      shiftIn_q, shiftIn_d;
   logic [7:0]      shiftOut_q, shiftOut_d;
   logic            isRead_q, isRead_d;
   logic [6:0]      addr_q, addr_d;
   wr_req_s         wr_q, wr_d;
   logic            miso_q, miso_d;
   logic            oeN_q, oeN_d;
   logic            rise, fall;

   assign rise = sclk & ~sclkPrev_q;
   assign fall = ~sclk & sclkPrev_q;

   always_comb begin
      sclkPrev_d = sclk;
      bitCnt_d   = bitCnt_q;
      shiftIn_d  = shiftIn_q;
      shiftOut_d = shiftOut_q;
      isRead_d   = isRead_q;
      addr_d     = addr_q;
      wr_d       = '0;
      miso_d     = miso_q;
      oeN_d      = csN;
      if (csN) begin
         bitCnt_d = '0;
      end else if (rise && bitCnt_q < FRAME_END_COUNT) begin
         shiftIn_d = {shiftIn_q[5:0], mosi};
         bitCnt_d  = bitCnt_q + 5'h01;
         if (bitCnt_q == CMD_LAST_BIT) begin
            isRead_d = shiftIn_q[6];
            addr_d   = {shiftIn_q[5:0], mosi};
         end else if (bitCnt_q == DATA_LAST_BIT && !isRead_q) begin
            wr_d = '{valid: 1'b1, addr: addr_q, data: {shiftIn_q, mosi}};
         end
      end else if (fall && bitCnt_q == DATA_FIRST_BIT) begin
         // read data captured once, so a later write cannot tear the byte
         shiftOut_d = rdData;
         miso_d     = rdData[7];
      end else if (fall && bitCnt_q > DATA_FIRST_BIT && bitCnt_q < FRAME_END_COUNT) begin
         miso_d     = shiftOut_q[6];
         shiftOut_d = {shiftOut_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sclkPrev_q <= 1'b0;
         bitCnt_q   <= '0;
         shiftIn_q  <= '0;
         shiftOut_q <= '0;
         isRead_q   <= 1'b0;
         addr_q     <= '0;
         wr_q       <= '0;
         miso_q     <= 1'b0;
         oeN_q      <= 1'b1;
      end else begin
         sclkPrev_q <= sclkPrev_d;
         bitCnt_q   <= bitCnt_d;
         shiftIn_q  <= shiftIn_d;
         shiftOut_q <= shiftOut_d;
         isRead_q   <= isRead_d;
         addr_q     <= addr_d;
         wr_q       <= wr_d;
         miso_q     <= miso_d;
         oeN_q      <= oeN_d;
      end
   end

   assign addr     = addr_q;
   assign wrReq    = wr_q;
   assign miso     = miso_q;
   assign misoOe_n = oeN_q;

endmodule // serial_frame_slave

// [tb/host_model.sv]
// host-side serial master model driving frames into the register bank
module host_model (
   input  wire logic clock,
   input  wire logic miso,
   input  wire logic misoOe_n,
   output logic      csN,
   output logic      sclk,
   output logic      mosi
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // frequency code, rounded to the nearest whole value
   function automatic logic [7:0] freqCode(input real f);
      return 8'(int'($floor(68.94 * $log10(f / 2000.0) + 0.5)));
   endfunction

   // sclk levels held 3 clocks, above the 2-clock minimum
   task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
      @(negedge clock);
      csN = 1'b0;
      @(negedge clock);
      for (int i = 15; i >= 0; i--) begin
         mosi = tx[i];
         repeat (3) @(negedge clock);
         if (i < 8) rx[i] = misoOe_n ? 1'bx : miso;
         sclk = 1'b1;
         repeat (3) @(negedge clock);
         sclk = 1'b0;
      end
      repeat (3) @(negedge clock);
      csN = 1'b1;
      // released line must not keep showing the last bit
      mosi = ~mosi;
      repeat (3) @(negedge clock);
   endtask
endmodule // host_model

// [tb/test_inductive_sense_config_regs.sv]
// self-checking bench for the sensing configuration register bank
module test_inductive_sense_config_regs
   import sense_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock = 1'b0;
   logic        reset_n;
   logic        csN;
   logic        sclk;
   logic        mosi;
   logic        activePowerSelect;
   logic        miso;
   logic        misoOe_n;
   logic [7:0]  minResistanceRange;
   logic        minResInRange;
   logic [7:0]  minResonanceFrequency;
   logic [1:0]  amplitudeSel;
   logic        amplitudeReserved;
   logic [12:0] responseCycles;
   logic        responseReserved;
   int          err_total = 0;
   int          num_checks = 0;
   logic [7:0]  fCode;

   always #20 clock = ~clock;

   inductive_sense_config_regs uut (
      .clock(clock), .reset_n(reset_n), .csN(csN), .sclk(sclk), .mosi(mosi),
      .activePowerSelect(activePowerSelect), .miso(miso), .misoOe_n(misoOe_n),
      .minResistanceRange(minResistanceRange), .minResInRange(minResInRange),
      .minResonanceFrequency(minResonanceFrequency), .amplitudeSel(amplitudeSel),
      .amplitudeReserved(amplitudeReserved), .responseCycles(responseCycles),
      .responseReserved(responseReserved));

   host_model host (.clock(clock), .miso(miso), .misoOe_n(misoOe_n),
      .csN(csN), .sclk(sclk), .mosi(mosi));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host.frame({1'b0, a, d}, unused);
   endtask

   task automatic rdChk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.frame({1'b1, a, 8'h00}, d);
      chk(d, exp);
   endtask

   task automatic t_reset();
      chk(minResistanceRange, 8'h14);
      chk(minResInRange, 1'b0);
      chk(minResonanceFrequency, 8'h45);
      chk({amplitudeReserved, amplitudeSel}, 3'h7);
      chk({responseReserved, responseCycles}, 14'h0180);
      rdChk(7'h04, 8'h1b);
      rdChk(7'h10, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_range();
      logic [7:0] c [4] = '{8'h1f, 8'h20, 8'h3f, 8'h40};
      foreach (c[i]) begin
         wr(7'h02, c[i]);
         chk(minResistanceRange, c[i]);
         chk(minResInRange, c[i] >= 8'h20 && c[i] <= 8'h3f);
         rdChk(7'h02, c[i]);
      end
      $display("test range done");
   endtask

   task automatic t_freq();
      fCode = host.freqCode(0.8 * 1.0e6);
      chk(fCode, 8'hb3);
      wr(7'h03, fCode);
      chk(minResonanceFrequency, fCode);
      rdChk(7'h03, fCode);
      $display("test frequency done");
   endtask

   // top bits set on purpose: they must be dropped
   task automatic t_config();
      logic [15:0] cyc;
      for (int a = 0; a < 4; a++) begin
         for (int r = 0; r < 8; r++) begin
            cyc = (r < 2) ? 16'h0000 : (16'h00c0 << (r - 2));
            wr(7'h04, {3'h7, 2'(a), 3'(r)});
            chk({amplitudeReserved, amplitudeSel}, {a == 3, 2'(a)});
            chk({responseReserved, responseCycles}, {r < 2, cyc[12:0]});
            rdChk(7'h04, {3'h0, 2'(a), 3'(r)});
         end
      end
      $display("test config done");
   endtask

   task automatic t_lock();
      @(negedge clock);
      activePowerSelect = 1'b1;
      wr(7'h02, 8'h33);
      wr(7'h03, 8'h10);
      wr(7'h04, 8'h0a);
      chk(minResistanceRange, 8'h40);
      chk(minResonanceFrequency, fCode);
      rdChk(7'h04, 8'h1f);
      activePowerSelect = 1'b0;
      wr(7'h02, 8'h33);
      chk(minResistanceRange, 8'h33);
      $display("test lock done");
   endtask

   // reset in mid-run must bring back every reset value
   task automatic t_midreset();
      wr(7'h03, 8'h5a);
      @(negedge clock);
      reset_n = 1'b0;
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      chk(misoOe_n, 1'b1);
      chk(minResistanceRange, 8'h14);
      chk(minResInRange, 1'b0);
      chk(minResonanceFrequency, 8'h45);
      chk({amplitudeReserved, amplitudeSel}, 3'h7);
      chk({responseReserved, responseCycles}, 14'h0180);
      rdChk(7'h04, 8'h1b);
      $display("test midreset done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      activePowerSelect = 1'b0;
      repeat (10) @(negedge clock);
      reset_n = 1'b1;
      t_reset();
      t_range();
      t_freq();
      t_config();
      t_lock();
      t_midreset();
      print_verdict();
   end

   initial begin
      repeat (100000) @(posedge clock);
      err_total++;
      print_verdict();
   end
endmodule // test_inductive_sense_config_regs
